/* bench/core_model.sv */
// core partner: takes an offered request once it has stood a set wait
// assumes it shares ref_clk and rstn with the controller
`default_nettype none

module core_model (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic ack_on,
  input wire logic [3:0] lat,
  input wire logic service_req,
  input wire logic [irq_prio_pkg::VEC_W-1:0] pending_vector_number,
  output logic take_ack,
  output logic [irq_prio_pkg::VEC_W-1:0] last_vec,
  output logic [7:0] n_take
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] wait_cnt;

  // ----
  // acceptance
  // ----
  // a busy core answers late; the offer must stand the whole wait
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      take_ack <= 1'b0;
      wait_cnt <= 4'h0;
      last_vec <= '0;
      n_take <= 8'h00;
    end
    else
    begin
      take_ack <= 1'b0;
      wait_cnt <= 4'h0;
      if (take_ack && service_req)
      begin
        last_vec <= pending_vector_number;
        n_take <= n_take + 8'h01;
      end
      if (ack_on && service_req && !take_ack)
      begin
        if (wait_cnt == lat)
          take_ack <= 1'b1;
        else
          wait_cnt <= wait_cnt + 4'h1;
      end
    end
  end
endmodule

`default_nettype wire

/* bench/tb.sv */
// self-checking bench for the interrupt priority controller
// assumes the core partner model and a 200 MHz ref_clk
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [15:0] rdata;
  logic [2:0] src_event = 3'h0;
  logic [3:0] trap_event = 4'h0;
  logic take_ack;
  logic ret = 1'b0;
  logic tdi = 1'b0;
  logic service_req;
  logic [6:0] pending_vector_number;
  logic [3:0] new_cpu_level;
  logic [3:0] cpu_level;
  logic lockout_active;
  logic irq;
  logic ack_on = 1'b0;
  logic [3:0] lat = 4'h1;
  logic [6:0] last_vec;
  logic [7:0] n_take;
  int n_mismatch = 0;
  int checks_done = 0;

  always #2.5 ref_clk = ~ref_clk;

  irq_prio_ctrl dut (.ref_clk(ref_clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .src_event(src_event), .trap_event(trap_event), .take_ack(take_ack),
    .return_from_handler(ret), .timed_disable_instruction(tdi), .service_req(service_req),
    .pending_vector_number(pending_vector_number), .new_cpu_level(new_cpu_level),
    .cpu_level(cpu_level), .lockout_active(lockout_active), .irq(irq));

  core_model core (.ref_clk(ref_clk), .rstn(rstn), .ack_on(ack_on), .lat(lat), .service_req(service_req),
    .pending_vector_number(pending_vector_number), .take_ack(take_ack), .last_vec(last_vec),
    .n_take(n_take));

  // ----
  // helpers
  // ----
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test;
    $display("mismatches %0d of %0d checks", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, input logic [15:0] exp);
    @(posedge ref_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    @(negedge ref_clk);
    chk(rdata, exp);
  endtask

  // one-cycle pulses on sources, traps, return and timed disable
  task automatic go(input logic [2:0] s, input logic [3:0] t, input logic r, input logic d);
    @(posedge ref_clk);
    src_event <= s;
    trap_event <= t;
    ret <= r;
    tdi <= d;
    @(posedge ref_clk);
    src_event <= 3'h0;
    trap_event <= 4'h0;
    ret <= 1'b0;
    tdi <= 1'b0;
  endtask

  task automatic look(input int n);
    repeat (n) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask

  task automatic wait_cpu(input logic [3:0] l);
    for (int i = 0; i < 30 && cpu_level !== l; i++)
      @(negedge ref_clk);
    chk({12'h0, cpu_level}, {12'h0, l});
  endtask

  initial
  begin
    repeat (5000) @(posedge ref_clk);
    n_mismatch++;
    end_of_test;
  end

  // ----
  // scenarios
  // ----
  initial
  begin
    logic [2:0] pc [5][3];
    logic [2:0] best;
    int w;
    int n;
    int k;
    pc = '{'{3'h2, 3'h5, 3'h7}, '{3'h7, 3'h7, 3'h7}, '{3'h0, 3'h3, 3'h3}, '{3'h0, 3'h0, 3'h0},
      '{3'h6, 3'h0, 3'h0}};
    repeat (16) @(posedge ref_clk);
    rstn <= 1'b1;
    rd(3'h3, 16'h0044);
    rd(3'h4, 16'h0040);
    rd(3'h7, 16'h0000);
    go(3'h1, 4'h0, 1'b0, 1'b0);
    look(2);
    chk({15'h0, irq | service_req}, 16'h0000);
    wr(3'h2, 16'h0001);
    look(1);
    chk({15'h0, irq}, 16'h0001);
    wr(3'h1, 16'h0001);
    look(1);
    chk({15'h0, irq}, 16'h0000);
    // all flagged and enabled, core idle: the pending register shows the winner
    wr(3'h2, 16'h0007);
    go(3'h7, 4'h0, 1'b0, 1'b0);
    for (k = 0; k < 5; k++)
    begin
      wr(3'h3, {9'h0, pc[k][0], 1'b0, pc[k][1]});
      wr(3'h4, {9'h0, pc[k][2], 4'h0});
      best = 3'h0;
      w = -1;
      for (int i = 0; i < 3; i++)
        if (pc[k][i] > best)
        begin
          best = pc[k][i];
          w = i;
        end
      look(3);
      if (w < 0)
        chk({15'h0, service_req}, 16'h0000);
      else
        rd(3'h5, {5'h0, best, 1'b0, irq_prio_pkg::SRC_VEC[w]});
    end
    wr(3'h6, 16'h0007);
    look(2);
    chk({15'h0, service_req}, 16'h0000);
    go(3'h0, 4'h8, 1'b0, 1'b0);
    look(3);
    rd(3'h5, {4'h0, 4'h8, 1'b0, irq_prio_pkg::TRAP_VEC[3]});
    chk({new_cpu_level, 5'h00, pending_vector_number}, {4'h8, 5'h00, irq_prio_pkg::TRAP_VEC[3]});
    wr(3'h0, 16'h0008);
    look(3);
    chk({15'h0, service_req}, 16'h0000);
    wr(3'h6, 16'h0000);
    look(3);
    chk({15'h0, service_req}, 16'h0001);
    go(3'h0, 4'h0, 1'b0, 1'b1);
    n = 0;
    for (int j = 0; j < 40; j++)
    begin
      @(negedge ref_clk);
      if (lockout_active === 1'b1)
        n++;
      if (j == 10)
        chk({15'h0, service_req}, 16'h0000);
    end
    chk(n[15:0], {8'h0, irq_prio_pkg::DISABLE_CYCLES});
    chk({15'h0, service_req}, 16'h0001);
    wr(3'h3, 16'h0070);
    go(3'h0, 4'h0, 1'b0, 1'b1);
    look(3);
    chk({14'h0, lockout_active, service_req}, 16'h0003);
    // nesting through the core model, first take answered slowly
    wr(3'h1, 16'h0007);
    wr(3'h3, 16'h0036);
    wr(3'h4, 16'h0000);
    wr(3'h0, 16'h8000);
    ack_on <= 1'b1;
    lat <= 4'h5;
    go(3'h1, 4'h0, 1'b0, 1'b0);
    wait_cpu(4'h3);
    chk({9'h0, last_vec}, {9'h0, irq_prio_pkg::SRC_VEC[0]});
    lat <= 4'h1;
    go(3'h2, 4'h0, 1'b0, 1'b0);
    look(8);
    chk({12'h0, cpu_level}, 16'h0003);
    wr(3'h0, 16'h0000);
    wait_cpu(4'h6);
    wr(3'h1, 16'h0002);
    go(3'h0, 4'h0, 1'b1, 1'b0);
    wait_cpu(4'h3);
    k = n_take;
    // leave the flag set: the handler must come straight back
    go(3'h0, 4'h0, 1'b1, 1'b0);
    for (int i = 0; i < 30 && n_take == k[7:0]; i++)
      @(negedge ref_clk);
    chk({8'h0, n_take}, k[15:0] + 16'h0001);
    wr(3'h1, 16'h0001);
    go(3'h0, 4'h0, 1'b1, 1'b0);
    look(4);
    chk({11'h0, service_req, cpu_level}, 16'h0000);
    end_of_test;
  end
endmodule

`default_nettype wire

/* design/disable_timer.sv */
// fixed-length lockout counter started by the timed disable instruction
// assumes start is a one-cycle pulse from the same clock domain
`default_nettype none

module disable_timer (
  input wire logic ref_clk,
  input wire logic rstn,
  timer_if.timer tif
);

  typedef struct packed {
    irq_prio_pkg::tmr_state_t state;
    logic [irq_prio_pkg::CNT_W-1:0] count;
  } tmr_t;

  tmr_t st_reg;
  tmr_t st_next;

  // a second start while running restarts the full period
  always_comb
  begin
    st_next = st_reg;
    case (st_reg.state)
      irq_prio_pkg::TMR_IDLE:
      begin
        if (tif.start)
        begin
          st_next.state = irq_prio_pkg::TMR_RUN;
          st_next.count = irq_prio_pkg::DISABLE_CYCLES - 8'h01;
        end
      end
      irq_prio_pkg::TMR_RUN:
      begin
        if (tif.start)
          st_next.count = irq_prio_pkg::DISABLE_CYCLES - 8'h01;
        else if (st_reg.count == 8'h00)
          st_next.state = irq_prio_pkg::TMR_IDLE;
        else
          st_next.count = st_reg.count - 8'h01;
      end
      default:
      begin
        st_next.state = irq_prio_pkg::TMR_IDLE;
        st_next.count = 8'h00;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_reg.state <= irq_prio_pkg::TMR_IDLE;
      st_reg.count <= 8'h00;
    end
    else
      st_reg <= st_next;
  end

  assign tif.busy = (st_reg.state == irq_prio_pkg::TMR_RUN);

  lockout_span_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    tif.start |=> tif.busy [*8])
    else $error("lockout ended too early");

endmodule

`default_nettype wire

/* design/irq_prio_ctrl.sv */
// priority interrupt controller: flags, enables, priorities, trap arbitration,
// nesting stack of cpu levels and pending status
// assumes sources and core are logic on ref_clk; register port is strobe style
`default_nettype none

// Operation
// - priority code 001 gives level 1 up to 111 giving level 7.
// - a priority field of 000 disables the source's request; irq still counts its flag.
// - every user priority field resets to level 4.
// - nesting disable bit 15 stops a user request preempting a running handler.
// - a source requests only while its enable bit is set.
// - flags stay set until software clears; uncleared flag re-enters after return.
// - return restores the saved cpu level from the stack.
// - trap handler must clear its trap flag or it is re-entered.
// - cpu level 7 masks all user requests; restoring it unmasks them.
// - traps at levels 8 to 15 cannot be masked by a user cpu level (0 to 7).
// - timed disable blocks levels 1 to 6 for a fixed period.
// - timed disable never blocks level 7 sources.
module irq_prio_ctrl (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [irq_prio_pkg::ADDR_W-1:0] addr,
  input wire logic [irq_prio_pkg::DATA_W-1:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [irq_prio_pkg::DATA_W-1:0] rdata,
  input wire logic [irq_prio_pkg::NUM_SRC-1:0] src_event,
  input wire logic [irq_prio_pkg::NUM_TRAP-1:0] trap_event,
  input wire logic take_ack,
  input wire logic return_from_handler,
  input wire logic timed_disable_instruction,
  output logic service_req,
  output logic [irq_prio_pkg::VEC_W-1:0] pending_vector_number,
  output logic [irq_prio_pkg::LVL_W-1:0] new_cpu_level,
  output logic [irq_prio_pkg::LVL_W-1:0] cpu_level,
  output logic lockout_active,
  output logic irq
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic nesting_disable;
    logic [irq_prio_pkg::NUM_TRAP-1:0] trap_flags;
    logic [irq_prio_pkg::NUM_SRC-1:0] flags;
    logic [irq_prio_pkg::NUM_SRC-1:0] enables;
    logic [irq_prio_pkg::NUM_SRC-1:0][irq_prio_pkg::PRIO_W-1:0] prio;
    logic [irq_prio_pkg::LVL_W-1:0] cpu_level;
    logic [irq_prio_pkg::LVL_W-1:0] depth;
    logic [irq_prio_pkg::STACK_DEPTH-1:0][irq_prio_pkg::LVL_W-1:0] stack;
    logic pend_valid;
    logic [irq_prio_pkg::LVL_W-1:0] pend_level;
    logic [irq_prio_pkg::VEC_W-1:0] pend_vec;
    logic [irq_prio_pkg::DATA_W-1:0] rdata;
  } ctrl_t;

  ctrl_t st_reg;
  ctrl_t st_next;

  logic [irq_prio_pkg::NUM_SRC-1:0] src_req;
  logic [irq_prio_pkg::NUM_SRC-1:0][irq_prio_pkg::LVL_W-1:0] src_level;
  logic nest_block;
  logic found;
  logic [irq_prio_pkg::LVL_W-1:0] best_lvl;
  logic [irq_prio_pkg::VEC_W-1:0] best_vec;
  logic take_now;
  logic pop_now;

  timer_if tmr ();

  // ----------------------------------------------------------------
  // lockout timer and per-source qualification
  // ----------------------------------------------------------------
  assign tmr.start = timed_disable_instruction;

  disable_timer u_timer (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .tif(tmr)
  );

  // nesting disable only holds back user sources, traps still preempt
  assign nest_block = st_reg.nesting_disable && (st_reg.depth != 4'h0);

  genvar g;
  generate
    for (g = 0; g < irq_prio_pkg::NUM_SRC; g++)
    begin : g_cell
      prio_cell u_cell (
        .flag(st_reg.flags[g]),
        .enable(st_reg.enables[g]),
        .prio(st_reg.prio[g]),
        .cpu_level(st_reg.cpu_level),
        .nest_block(nest_block),
        .lockout(tmr.busy),
        .req(src_req[g]),
        .level(src_level[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // arbitration
  // ----------------------------------------------------------------
  // strict compare in index order: equal levels go to the lower index
  always_comb
  begin
    best_lvl = 4'h0;
    best_vec = 7'h00;
    for (int i = 0; i < irq_prio_pkg::NUM_TRAP; i++)
    begin
      if (st_reg.trap_flags[i] && (irq_prio_pkg::TRAP_LEVEL[i] > st_reg.cpu_level)
          && (irq_prio_pkg::TRAP_LEVEL[i] > best_lvl))
      begin
        best_lvl = irq_prio_pkg::TRAP_LEVEL[i];
        best_vec = irq_prio_pkg::TRAP_VEC[i];
      end
    end
    for (int i = 0; i < irq_prio_pkg::NUM_SRC; i++)
    begin
      if (src_req[i] && (src_level[i] > best_lvl))
      begin
        best_lvl = src_level[i];
        best_vec = irq_prio_pkg::SRC_VEC[i];
      end
    end
    found = (best_lvl != 4'h0);
  end

  // return has precedence; a take in the same cycle is ignored
  assign pop_now = return_from_handler && (st_reg.depth != 4'h0);
  assign take_now = take_ack && st_reg.pend_valid && !pop_now;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [irq_prio_pkg::NUM_SRC-1:0] src_clr;
    logic [irq_prio_pkg::NUM_TRAP-1:0] trap_clr;
    src_clr = '0;
    trap_clr = '0;
    st_next = st_reg;

    if (wr_en)
    begin
      case (addr)
        irq_prio_pkg::OFF_CTRL_FIRST:
        begin
          st_next.nesting_disable = wdata[irq_prio_pkg::NEST_DIS_BIT];
          trap_clr = wdata[irq_prio_pkg::TRAP_LSB +: irq_prio_pkg::NUM_TRAP];
        end
        irq_prio_pkg::OFF_FLAGS:
          src_clr = wdata[irq_prio_pkg::NUM_SRC-1:0];
        irq_prio_pkg::OFF_ENABLE:
          st_next.enables = wdata[irq_prio_pkg::NUM_SRC-1:0];
        irq_prio_pkg::OFF_PRIO_UART_FAULT:
        begin
          st_next.prio[0] = wdata[irq_prio_pkg::PRIO_UART_LSB +: irq_prio_pkg::PRIO_W];
          st_next.prio[1] = wdata[irq_prio_pkg::PRIO_FAULT_LSB +: irq_prio_pkg::PRIO_W];
        end
        irq_prio_pkg::OFF_PRIO_TOUCH:
          st_next.prio[2] = wdata[irq_prio_pkg::PRIO_TOUCH_LSB +: irq_prio_pkg::PRIO_W];
        irq_prio_pkg::OFF_CPU_LEVEL:
        begin
          // software sets user levels only; a trap level is left alone
          if (st_reg.cpu_level <= irq_prio_pkg::USER_TOP)
            st_next.cpu_level = {1'b0, wdata[irq_prio_pkg::PRIO_W-1:0]};
        end
        default:
        begin
        end
      endcase
    end

    // a new event beats a clear in the same cycle
    st_next.flags = (st_reg.flags & ~src_clr) | src_event;
    st_next.trap_flags = (st_reg.trap_flags & ~trap_clr) | trap_event;

    if (pop_now)
    begin
      st_next.cpu_level = st_reg.stack[3'(st_reg.depth - 4'h1)];
      st_next.depth = st_reg.depth - 4'h1;
    end
    else if (take_now)
    begin
      // a full stack skips the new save and keeps depth at eight; nesting past eight is unsupported
      if (st_reg.depth < irq_prio_pkg::DEPTH_FULL)
      begin
        st_next.stack[3'(st_reg.depth)] = st_reg.cpu_level;
        st_next.depth = st_reg.depth + 4'h1;
      end
      st_next.cpu_level = st_reg.pend_level;
    end

    // drop the pending view for a cycle whenever a take or a return moves the cpu level
    st_next.pend_valid = found && !take_now && !pop_now;
    st_next.pend_level = best_lvl;
    st_next.pend_vec = best_vec;

    st_next.rdata = '0;
    if (rd_en)
    begin
      case (addr)
        irq_prio_pkg::OFF_CTRL_FIRST:
        begin
          st_next.rdata[irq_prio_pkg::NEST_DIS_BIT] = st_reg.nesting_disable;
          st_next.rdata[irq_prio_pkg::TRAP_LSB +: irq_prio_pkg::NUM_TRAP] = st_reg.trap_flags;
        end
        irq_prio_pkg::OFF_FLAGS:
          st_next.rdata[irq_prio_pkg::NUM_SRC-1:0] = st_reg.flags;
        irq_prio_pkg::OFF_ENABLE:
          st_next.rdata[irq_prio_pkg::NUM_SRC-1:0] = st_reg.enables;
        irq_prio_pkg::OFF_PRIO_UART_FAULT:
        begin
          st_next.rdata[irq_prio_pkg::PRIO_UART_LSB +: irq_prio_pkg::PRIO_W] = st_reg.prio[0];
          st_next.rdata[irq_prio_pkg::PRIO_FAULT_LSB +: irq_prio_pkg::PRIO_W] = st_reg.prio[1];
        end
        irq_prio_pkg::OFF_PRIO_TOUCH:
          st_next.rdata[irq_prio_pkg::PRIO_TOUCH_LSB +: irq_prio_pkg::PRIO_W] = st_reg.prio[2];
        irq_prio_pkg::OFF_PENDING:
        begin
          st_next.rdata[irq_prio_pkg::PEND_LEVEL_LSB +: irq_prio_pkg::LVL_W] = st_reg.pend_level;
          st_next.rdata[irq_prio_pkg::PEND_VEC_LSB +: irq_prio_pkg::VEC_W] = st_reg.pend_vec;
        end
        irq_prio_pkg::OFF_CPU_LEVEL:
          st_next.rdata[irq_prio_pkg::LVL_W-1:0] = st_reg.cpu_level;
        default:
          st_next.rdata = '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_reg <= '0;
      st_reg.prio <= {irq_prio_pkg::NUM_SRC{irq_prio_pkg::PRIO_RESET}};
      st_reg.cpu_level <= irq_prio_pkg::CPU_LEVEL_RESET;
    end
    else
      st_reg <= st_next;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign rdata = st_reg.rdata;
  assign service_req = st_reg.pend_valid;
  assign pending_vector_number = st_reg.pend_vec;
  assign new_cpu_level = st_reg.pend_level;
  assign cpu_level = st_reg.cpu_level;
  assign lockout_active = tmr.busy;
  assign irq = |(st_reg.flags & st_reg.enables);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  sequence take_seq;
    take_ack && st_reg.pend_valid && !pop_now;
  endsequence

  // top of the level stack, what a return has to bring back
  logic [irq_prio_pkg::LVL_W-1:0] top_saved;
  assign top_saved = st_reg.stack[3'(st_reg.depth - 4'h1)];

  sequence pop_seq;
    pop_now;
  endsequence

  prio_reset_a: assert property (
    !$past(rstn) |-> (st_reg.prio[0] == irq_prio_pkg::PRIO_RESET) && (st_reg.prio[2] == irq_prio_pkg::PRIO_RESET))
    else $error("priority did not reset to level 4");

  zero_prio_a: assert property (
    (st_reg.pend_valid && st_reg.pend_vec == irq_prio_pkg::SRC_VEC[0])
      |-> ($past(st_reg.prio[0]) != irq_prio_pkg::PRIO_OFF))
    else $error("disabled source was selected");

  enable_gate_a: assert property (
    (st_reg.pend_valid && st_reg.pend_vec == irq_prio_pkg::SRC_VEC[1]) |-> $past(st_reg.enables[1]))
    else $error("source selected while not enabled");

  take_level_a: assert property (
    take_seq |=> (st_reg.cpu_level == $past(st_reg.pend_level)) && !st_reg.pend_valid)
    else $error("cpu level not raised to taken level");

  return_restore_a: assert property (
    pop_seq |=> (st_reg.cpu_level == $past(top_saved)) && (st_reg.depth == $past(st_reg.depth) - 4'h1))
    else $error("return did not restore saved level");

  flag_sticky_a: assert property (
    st_reg.flags[0] && !(wr_en && addr == irq_prio_pkg::OFF_FLAGS && wdata[0]) |=> st_reg.flags[0])
    else $error("flag dropped without software clear");

  mask_seven_a: assert property (
    (st_reg.pend_valid && $past(st_reg.cpu_level) == irq_prio_pkg::USER_TOP)
      |-> st_reg.pend_level > irq_prio_pkg::USER_TOP)
    else $error("user request passed cpu level 7");

  trap_pass_a: assert property (
    (st_reg.trap_flags[3] && st_reg.trap_flags[2:0] == 3'h0 && st_reg.cpu_level <= irq_prio_pkg::USER_TOP
      && !take_ack && !return_from_handler)
      |=> service_req && new_cpu_level == irq_prio_pkg::TRAP_LEVEL[3])
    else $error("trap blocked by cpu level");

  nest_hold_a: assert property (
    (st_reg.pend_valid && $past(nest_block)) |-> st_reg.pend_level > irq_prio_pkg::USER_TOP)
    else $error("user request preempted with nesting disabled");

  lockout_low_a: assert property (
    (st_reg.pend_valid && $past(tmr.busy)) |-> st_reg.pend_level > irq_prio_pkg::LOCKOUT_TOP)
    else $error("level 1 to 6 taken during lockout");

  lockout_seven_a: assert property (
    (tmr.busy && st_reg.flags[0] && st_reg.enables[0] && st_reg.prio[0] == 3'h7
      && st_reg.cpu_level < irq_prio_pkg::USER_TOP && st_reg.trap_flags == '0 && !take_ack && !pop_now
      && !nest_block)
      |=> service_req && new_cpu_level == irq_prio_pkg::USER_TOP)
    else $error("level 7 blocked during lockout");

  pend_report_a: assert property (
    (st_reg.flags[2] && st_reg.enables[2] && ({1'b0, st_reg.prio[2]} > st_reg.cpu_level)
      && (st_reg.prio[2] > st_reg.prio[1]) && (st_reg.prio[2] > st_reg.prio[0])
      && !tmr.busy && !nest_block && st_reg.trap_flags == '0 && !take_ack && !return_from_handler)
      |=> service_req && pending_vector_number == irq_prio_pkg::SRC_VEC[2]
        && !new_cpu_level[3] && new_cpu_level[2:0] == $past(st_reg.prio[2]))
    else $error("pending status does not match winner");

endmodule

`default_nettype wire

/* design/irq_prio_pkg.sv */
// constants, register map and types shared by the interrupt priority logic
// assumes a single 200 MHz clock and a plain strobe-style register port
`default_nettype none

package irq_prio_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int unsigned NUM_SRC = 3;
  localparam int unsigned NUM_TRAP = 4;
  localparam int unsigned ADDR_W = 3;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned LVL_W = 4;
  localparam int unsigned PRIO_W = 3;
  localparam int unsigned VEC_W = 7;
  localparam int unsigned STACK_DEPTH = 8;
  localparam int unsigned CNT_W = 8;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFF_CTRL_FIRST = 3'h0;
  localparam logic [ADDR_W-1:0] OFF_FLAGS = 3'h1;
  localparam logic [ADDR_W-1:0] OFF_ENABLE = 3'h2;
  localparam logic [ADDR_W-1:0] OFF_PRIO_UART_FAULT = 3'h3;
  localparam logic [ADDR_W-1:0] OFF_PRIO_TOUCH = 3'h4;
  localparam logic [ADDR_W-1:0] OFF_PENDING = 3'h5;
  localparam logic [ADDR_W-1:0] OFF_CPU_LEVEL = 3'h6;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned NEST_DIS_BIT = 15;
  localparam int unsigned TRAP_LSB = 0;
  localparam int unsigned PRIO_UART_LSB = 4;
  localparam int unsigned PRIO_FAULT_LSB = 0;
  localparam int unsigned PRIO_TOUCH_LSB = 4;
  localparam int unsigned PEND_LEVEL_LSB = 8;
  localparam int unsigned PEND_VEC_LSB = 0;

  // ----------------------------------------------------------------
  // reset values and level codes
  // ----------------------------------------------------------------
  localparam logic [PRIO_W-1:0] PRIO_RESET = 3'h4;
  localparam logic [PRIO_W-1:0] PRIO_OFF = 3'h0;
  localparam logic [LVL_W-1:0] USER_TOP = 4'h7;
  localparam logic [LVL_W-1:0] LOCKOUT_TOP = 4'h6;
  localparam logic [LVL_W-1:0] CPU_LEVEL_RESET = 4'h0;
  localparam logic [LVL_W-1:0] DEPTH_FULL = 4'h8;

  // vector numbers and trap levels: values arbitrary
  localparam logic [VEC_W-1:0] SRC_VEC [NUM_SRC] = '{7'h2a, 7'h2b, 7'h2c};
  localparam logic [VEC_W-1:0] TRAP_VEC [NUM_TRAP] = '{7'h01, 7'h02, 7'h03, 7'h04};
  localparam logic [LVL_W-1:0] TRAP_LEVEL [NUM_TRAP] = '{4'hf, 4'hd, 4'hb, 4'h8};

  // ----------------------------------------------------------------
  // timed disable period
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned DISABLE_TIME_NS = 100;
  localparam logic [CNT_W-1:0] DISABLE_CYCLES =
    CNT_W'((DISABLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  typedef enum logic [1:0] {
    TMR_IDLE = 2'b01,
    TMR_RUN = 2'b10
  } tmr_state_t;

endpackage

`default_nettype wire

/* design/prio_cell.sv */
// one user source: qualifies its request against the cpu level and masks
// assumes all inputs come from registers on the same clock
`default_nettype none

module prio_cell (
  input wire logic flag,
  input wire logic enable,
  input wire logic [irq_prio_pkg::PRIO_W-1:0] prio,
  input wire logic [irq_prio_pkg::LVL_W-1:0] cpu_level,
  input wire logic nest_block,
  input wire logic lockout,
  output logic req,
  output logic [irq_prio_pkg::LVL_W-1:0] level
);

  always_comb
  begin
    level = {1'b0, prio};
    req = flag && enable
      && (prio != irq_prio_pkg::PRIO_OFF)
      && (level > cpu_level)
      && !nest_block
      && !(lockout && (level <= irq_prio_pkg::LOCKOUT_TOP));
  end

endmodule

`default_nettype wire

/* design/timer_if.sv */
// handshake between the controller and the timed-disable counter
// assumes both ends run on the same clock
`default_nettype none

interface timer_if;
  logic start;
  logic busy;
  modport ctrl (output start, input busy);
  modport timer (input start, output busy);
endinterface

`default_nettype wire
